// [rtl/adcsfs_top.v]
// serial frame sequencer of a multichannel sampling converter
// How it works
// - chip-select fall starts frame and sample
// - 16-bit word: address or GPIO, result
// - mux switches on second falling edge
// - acquire from rise 14 to next frame
// - GPO refresh at chip-select fall
// - GPI latched, sent if asked before
// - address bits: frame start, falls 1-3
// - result MSB fall 4, LSB by resolution
// - fall 16 ends conversion, releases SDO
// - one input bit per rising edge
// - per-channel high/low thresholds raise alarms
// - alarm set fall 12, cleared fall 10
// - power-down bit acts next frame's fall 16
// - pin power-down immediate, wake on select
// - manual channel used next frame
// - reset: manual mode, channel zero
// - mask scan ascending, mask persists
// - mask resets to all channels
// - range scan zero to last channel
// - last channel resets to highest
// - programming any frame, operation continues
// - manual fields change only when enabled
`timescale 1ns/1ps
`default_nettype none
`include "adcsfs_map.vh"
module adcsfs_top #(
   parameter NUM_CH   = 16,
   parameter RES_BITS = 12
) (
   input  wire        CLK,
   input  wire        RESETN,
   input  wire        CS_N,
   input  wire        SCLK,
   input  wire        SDI,
   input  wire [11:0] CONV_RESULT,
   input  wire [3:0]  GPIO_IN,
   output reg         SDO_OUT,
   output reg         SDO_OE,
   output reg  [3:0]  GPIO_OUT,
   output reg  [3:0]  GPIO_OE,
   output reg  [3:0]  MUX_CH,
   output reg  [3:0]  SAMPLE_CH,
   output reg         SAMPLE_STROBE,
   output reg         CONVERTING,
   output reg         ACQUIRE,
   output reg         RANGE_SEL,
   output reg         POWERED_DOWN
);
   localparam [15:0] MASK_RST = (NUM_CH >= 16) ? 16'hFFFF : (16'hFFFF >> (16 - NUM_CH));
   localparam integer LAST_INT = NUM_CH - 1;
   localparam [3:0]  LAST_RST = LAST_INT[3:0];
   localparam [11:0] RES_MASK = 12'hFFF << (12 - RES_BITS);

   wire [6:0]  pin_s;
   wire        cs_s   = pin_s[6];
   wire        sclk_s = pin_s[5];
   wire        sdi_s  = pin_s[4];
   wire [3:0]  gpi_s  = pin_s[3:0];

   adcsfs_sync #(
      .W       (7),
      .RST_VAL (7'h40)
   ) u_sync (
      .clk    (CLK),
      .resetn (RESETN),
      .din    ({CS_N, SCLK, SDI, GPIO_IN}),
      .dout   (pin_s)
   );

   reg         cs_d_r;
   reg         sclk_d_r;
   reg [4:0]   fall_cnt_r;
   reg [4:0]   rise_cnt_r;
   reg [15:0]  rx_r;
   reg [1:0]   mode_r;
   reg [3:0]   man_ch_r;
   reg         range_r;
   reg         pd_bit_r;
   reg         rb_r;
   reg [3:0]   gpo_r;
   reg [3:0]   gpo_act_r;
   reg [15:0]  mask_r;
   reg [3:0]   last_r;
   reg         mask_arm_r;
   reg         restart_r;
   reg [3:0]   gp_dir_r;
   reg         hi_en_r;
   reg         lo_en_r;
   reg         pdpin_en_r;
   reg [3:0]   addr_r;
   reg [11:0]  result_r;
   reg         hi_al_r;
   reg         lo_al_r;
   reg         pd_arm_r;
   reg [7:0]   thr_lo_r [0:15];
   reg [7:0]   thr_hi_r [0:15];
   wire [3:0]  next_ch;

   wire cs_fall    = cs_d_r & ~cs_s;
   wire sclk_rise  = ~cs_s & ~sclk_d_r & sclk_s;
   wire sclk_fall  = ~cs_s & sclk_d_r & ~sclk_s;
   wire [4:0] fall_nxt = fall_cnt_r + 5'd1;
   wire [4:0] rise_nxt = rise_cnt_r + 5'd1;
   wire [15:0] tx_w    = {addr_r, result_r};
   wire [15:0] word_in = {rx_r[14:0], sdi_s};
   wire word_done = sclk_rise && rise_nxt == `ADCSFS_LAST_EDGE;
   wire pin_pd    = pdpin_en_r & ~gpi_s[3];

   adcsfs_chsel u_chsel (
      .mode    (mode_r),
      .cur     (MUX_CH),
      .man_ch  (man_ch_r),
      .mask    (mask_r),
      .last    (last_r),
      .restart (restart_r),
      .next    (next_ch)
   );

   // edge tracking and frame counters
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cs_d_r     <= 1'b1;
         sclk_d_r   <= 1'b0;
         fall_cnt_r <= 5'd0;
         rise_cnt_r <= 5'd0;
         rx_r       <= 16'h0000;
      end else begin
         cs_d_r   <= cs_s;
         sclk_d_r <= sclk_s;
         if (cs_fall) begin
            fall_cnt_r <= 5'd0;
            rise_cnt_r <= 5'd0;
         end else begin
            if (sclk_fall && fall_cnt_r != `ADCSFS_LAST_EDGE) begin
               fall_cnt_r <= fall_nxt;
            end
            if (sclk_rise && rise_cnt_r != `ADCSFS_LAST_EDGE) begin
               rise_cnt_r <= rise_nxt;
               rx_r       <= word_in;
            end
         end
      end
   end

   // serial output and conversion timing
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         SDO_OUT       <= 1'b0;
         SDO_OE        <= 1'b0;
         SAMPLE_CH     <= 4'h0;
         SAMPLE_STROBE <= 1'b0;
         CONVERTING    <= 1'b0;
         ACQUIRE       <= 1'b0;
         addr_r        <= 4'h0;
         result_r      <= 12'h000;
      end else begin
         SAMPLE_STROBE <= cs_fall;
         if (cs_fall) begin
            SAMPLE_CH  <= MUX_CH;
            CONVERTING <= 1'b1;
            ACQUIRE    <= 1'b0;
            SDO_OE     <= 1'b1;
            addr_r     <= rb_r ? gpi_s : MUX_CH;
            SDO_OUT    <= rb_r ? gpi_s[3] : MUX_CH[3];
            result_r   <= 12'h000;
         end else begin
            if (sclk_fall && fall_cnt_r != `ADCSFS_LAST_EDGE) begin
               if (fall_nxt == `ADCSFS_LAST_EDGE) begin
                  SDO_OE     <= 1'b0;
                  SDO_OUT    <= 1'b0;
                  CONVERTING <= 1'b0;
               end else begin
                  SDO_OUT <= tx_w[4'd15 - fall_nxt[3:0]];
               end
               if (fall_nxt == `ADCSFS_RES_FALL) begin
                  result_r <= CONV_RESULT & RES_MASK;
               end
            end
            if (sclk_rise && rise_nxt == `ADCSFS_ACQ_RISE) begin
               ACQUIRE <= 1'b1;
            end
         end
      end
   end

   // multiplexer stepping
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         MUX_CH    <= 4'h0;
         restart_r <= 1'b0;
      end else begin
         if (sclk_fall && fall_nxt == `ADCSFS_MUX_FALL) begin
            MUX_CH    <= next_ch;
            restart_r <= 1'b0;
         end else if (word_done && !mask_arm_r && word_in[`ADCSFS_PROG_EN] &&
                      (word_in[15:12] == `ADCSFS_CMD_MASK ||
                       word_in[15:12] == `ADCSFS_CMD_RANGE)) begin
            restart_r <= word_in[`ADCSFS_RESTART];
         end
      end
   end

   // input word decode
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         mode_r     <= `ADCSFS_MODE_MANUAL;
         man_ch_r   <= 4'h0;
         range_r    <= 1'b0;
         pd_bit_r   <= 1'b0;
         rb_r       <= 1'b0;
         gpo_r      <= 4'h0;
         mask_r     <= MASK_RST;
         last_r     <= LAST_RST;
         mask_arm_r <= 1'b0;
         gp_dir_r   <= 4'h0;
         hi_en_r    <= 1'b0;
         lo_en_r    <= 1'b0;
         pdpin_en_r <= 1'b0;
      end else if (word_done) begin
         if (mask_arm_r) begin
            mask_r     <= word_in & MASK_RST;
            mask_arm_r <= 1'b0;
         end else begin
            case (word_in[15:12])
               `ADCSFS_CMD_MANUAL, `ADCSFS_CMD_MASK, `ADCSFS_CMD_RANGE: begin
                  mode_r <= (word_in[15:12] == `ADCSFS_CMD_MANUAL) ? `ADCSFS_MODE_MANUAL :
                            (word_in[15:12] == `ADCSFS_CMD_MASK) ? `ADCSFS_MODE_MASK :
                            `ADCSFS_MODE_RANGE;
                  if (word_in[`ADCSFS_PROG_EN]) begin
                     if (word_in[15:12] == `ADCSFS_CMD_MANUAL) begin
                        man_ch_r <= word_in[`ADCSFS_CH_HI:`ADCSFS_CH_LO];
                     end
                     range_r  <= word_in[`ADCSFS_RANGE_BIT];
                     pd_bit_r <= word_in[`ADCSFS_PD_BIT];
                     rb_r     <= word_in[`ADCSFS_RB_BIT];
                     gpo_r    <= word_in[3:0];
                  end
               end
               `ADCSFS_CMD_PMASK: begin
                  mask_arm_r <= 1'b1;
               end
               `ADCSFS_CMD_PLAST: begin
                  last_r <= word_in[`ADCSFS_LAST_HI:`ADCSFS_LAST_LO];
               end
               `ADCSFS_CMD_GPIO: begin
                  gp_dir_r   <= word_in[3:0];
                  hi_en_r    <= word_in[`ADCSFS_GP_HI_EN];
                  lo_en_r    <= word_in[`ADCSFS_GP_LO_EN];
                  pdpin_en_r <= word_in[`ADCSFS_GP_PD_EN];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // alarm thresholds per channel
   genvar c;
   generate
      for (c = 0; c < 16; c = c + 1) begin : g_thr
         always @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
               thr_lo_r[c] <= `ADCSFS_THR_LO_RST;
               thr_hi_r[c] <= `ADCSFS_THR_HI_RST;
            end else if (word_done && word_in[11:8] == c) begin
               if (word_in[15:12] == `ADCSFS_CMD_THR_LO && !mask_arm_r) begin
                  thr_lo_r[c] <= word_in[7:0];
               end
               if (word_in[15:12] == `ADCSFS_CMD_THR_HI && !mask_arm_r) begin
                  thr_hi_r[c] <= word_in[7:0];
               end
            end
         end
      end
   endgenerate

   // alarm flags
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         hi_al_r <= 1'b0;
         lo_al_r <= 1'b0;
      end else if (sclk_fall) begin
         if (fall_nxt == `ADCSFS_AL_SET_FALL) begin
            hi_al_r <= result_r[11:4] > thr_hi_r[SAMPLE_CH];
            lo_al_r <= result_r[11:4] < thr_lo_r[SAMPLE_CH];
         end else if (fall_nxt == `ADCSFS_AL_CLR_FALL) begin
            hi_al_r <= 1'b0;
            lo_al_r <= 1'b0;
         end
      end
   end

   // general purpose pins and range
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         gpo_act_r <= 4'h0;
         GPIO_OUT  <= 4'h0;
         GPIO_OE   <= 4'h0;
         RANGE_SEL <= 1'b0;
      end else begin
         if (cs_fall) begin
            gpo_act_r <= gpo_r;
            RANGE_SEL <= range_r;
         end
         GPIO_OUT <= {gpo_act_r[3:2],
                      lo_en_r ? lo_al_r : gpo_act_r[1],
                      hi_en_r ? hi_al_r : gpo_act_r[0]};
         GPIO_OE  <= {gp_dir_r[3] & ~pdpin_en_r, gp_dir_r[2],
                      gp_dir_r[1] | lo_en_r, gp_dir_r[0] | hi_en_r};
      end
   end

   // power-down control
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pd_arm_r     <= 1'b0;
         POWERED_DOWN <= 1'b0;
      end else begin
         if (cs_fall) begin
            pd_arm_r <= pd_bit_r;
         end
         if (pin_pd) begin
            POWERED_DOWN <= 1'b1;
         end else if (cs_fall && !pd_bit_r) begin
            POWERED_DOWN <= 1'b0;
         end else if (sclk_fall && fall_nxt == `ADCSFS_LAST_EDGE && pd_arm_r) begin
            POWERED_DOWN <= 1'b1;
         end
      end
   end
endmodule // adcsfs_top
`default_nettype wire

// [common/adcsfs_map.vh]
// field positions, command codes and reset values of the frame sequencer
`ifndef ADCSFS_MAP_VH
`define ADCSFS_MAP_VH
// frame edge counts
`define ADCSFS_MUX_FALL    5'd2
`define ADCSFS_RES_FALL    5'd3
`define ADCSFS_AL_CLR_FALL 5'd10
`define ADCSFS_AL_SET_FALL 5'd12
`define ADCSFS_ACQ_RISE    5'd14
`define ADCSFS_LAST_EDGE   5'd16
// command codes, input word bits 15..12
`define ADCSFS_CMD_KEEP    4'h0
`define ADCSFS_CMD_MANUAL  4'h1
`define ADCSFS_CMD_MASK    4'h2
`define ADCSFS_CMD_RANGE   4'h3
`define ADCSFS_CMD_GPIO    4'h4
`define ADCSFS_CMD_PMASK   4'h8
`define ADCSFS_CMD_PLAST   4'h9
`define ADCSFS_CMD_THR_LO  4'hC
`define ADCSFS_CMD_THR_HI  4'hD
// sequencing modes
`define ADCSFS_MODE_MANUAL 2'd0
`define ADCSFS_MODE_MASK   2'd1
`define ADCSFS_MODE_RANGE  2'd2
// input word fields
`define ADCSFS_PROG_EN     11
`define ADCSFS_RESTART     10
`define ADCSFS_CH_HI       10
`define ADCSFS_CH_LO       7
`define ADCSFS_RANGE_BIT   6
`define ADCSFS_PD_BIT      5
`define ADCSFS_RB_BIT      4
`define ADCSFS_LAST_HI     9
`define ADCSFS_LAST_LO     6
`define ADCSFS_GP_HI_EN    4
`define ADCSFS_GP_LO_EN    5
`define ADCSFS_GP_PD_EN    6
// reset values
`define ADCSFS_THR_HI_RST  8'hFF
`define ADCSFS_THR_LO_RST  8'h00
`endif

// [rtl/adcsfs_sync.v]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module adcsfs_sync #(
   parameter         W       = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input  wire         clk,
   input  wire         resetn,
   input  wire [W-1:0] din,
   output wire [W-1:0] dout
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg s1_r;
         reg s2_r;
         reg s3_r;
         reg q_r;
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               s1_r <= RST_VAL[i];
               s2_r <= RST_VAL[i];
               s3_r <= RST_VAL[i];
               q_r  <= RST_VAL[i];
            end else begin
               s1_r <= din[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               // accept once second and third agree
               if (s2_r == s3_r) begin
                  q_r <= s3_r;
               end
            end
         end
         assign dout[i] = q_r;
      end
   endgenerate
endmodule // adcsfs_sync
`default_nettype wire

// [rtl/adcsfs_chsel.v]
// next multiplexer channel for the three sequencing modes
`timescale 1ns/1ps
`default_nettype none
`include "adcsfs_map.vh"
module adcsfs_chsel (
   input  wire [1:0]  mode,
   input  wire [3:0]  cur,
   input  wire [3:0]  man_ch,
   input  wire [15:0] mask,
   input  wire [3:0]  last,
   input  wire        restart,
   output reg  [3:0]  next
);
   integer   i;
   reg [3:0] lowest;
   reg [3:0] above;
   reg       has_above;
   always @* begin
      lowest    = 4'h0;
      above     = 4'h0;
      has_above = 1'b0;
      // scan from the top so the lowest match wins
      for (i = 15; i >= 0; i = i - 1) begin
         if (mask[i]) begin
            lowest = i[3:0];
            if (i[3:0] > cur) begin
               above     = i[3:0];
               has_above = 1'b1;
            end
         end
      end
      case (mode)
         `ADCSFS_MODE_MASK: begin
            next = (restart || !has_above) ? lowest : above;
         end
         `ADCSFS_MODE_RANGE: begin
            next = (restart || cur >= last) ? 4'h0 : cur + 4'h1;
         end
         default: begin
            next = man_ch;
         end
      endcase
   end
endmodule // adcsfs_chsel
`default_nettype wire

// [bench/adcsfs_props.sv]
// port assertions for the frame sequencer
`timescale 1ns/1ps
`default_nettype none
module adcsfs_props_chk (
   input wire logic       CLK,
   input wire logic       RESETN,
   input wire logic       CS_N,
   input wire logic       SDO_OUT,
   input wire logic       SDO_OE,
   input wire logic [3:0] MUX_CH,
   input wire logic [3:0] SAMPLE_CH,
   input wire logic       SAMPLE_STROBE,
   input wire logic       CONVERTING,
   input wire logic       ACQUIRE
);
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   strobe_start_a: assert property ($fell(CS_N) |-> ##[2:8] SAMPLE_STROBE)
      else $error("no strobe after select fall");
   strobe_pulse_a: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE && CONVERTING)
      else $error("strobe not a single pulse");
   sample_ch_a: assert property (SAMPLE_STROBE |-> SAMPLE_CH == $past(MUX_CH))
      else $error("sampled channel not mux channel");
   frame_open_a: assert property (SAMPLE_STROBE |-> SDO_OE && CONVERTING && !ACQUIRE)
      else $error("frame start outputs wrong");
   first_bit_a: assert property (SAMPLE_STROBE |=> $stable(SDO_OUT)[*6])
      else $error("first bit left early");
   mux_late_a: assert property (SAMPLE_STROBE |-> ##1 $stable(MUX_CH)[*5])
      else $error("mux moved before second fall");
   mux_frame_a: assert property ($changed(MUX_CH) |-> CONVERTING && !ACQUIRE)
      else $error("mux moved outside frame");
   acq_start_a: assert property ($rose(ACQUIRE) |-> CONVERTING && SDO_OE)
      else $error("acquire began outside frame");
   acq_hold_a: assert property (ACQUIRE |=> ACQUIRE || SAMPLE_STROBE)
      else $error("acquire ended before frame");
   oe_end_a: assert property ($fell(SDO_OE) |-> $fell(CONVERTING) && ACQUIRE)
      else $error("output release not at frame end");
   idle_off_a: assert property (CS_N [*8] |-> !SDO_OE && !CONVERTING)
      else $error("output driven while idle");
endmodule // adcsfs_props_chk
bind adcsfs_top adcsfs_props_chk adcsfs_props_chk_inst (
   .CLK, .RESETN, .CS_N, .SDO_OUT, .SDO_OE, .MUX_CH, .SAMPLE_CH, .SAMPLE_STROBE,
   .CONVERTING, .ACQUIRE
);
`default_nettype wire

// [bench/adcsfs_host.sv]
// host serial port model driving frames
`timescale 1ns/1ps
`default_nettype none
module adcsfs_host (
   output var logic        cs_n,
   output var logic        sclk,
   output var logic        sdi,
   output var logic [15:0] rd,
   output var logic        done,
   input  wire logic       sdo
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi  = 1'b0;
      rd   = 16'h0000;
      done = 1'b0;
   end
   // one frame, then idle for a variable gap
   task automatic xfer(input logic [15:0] w, input logic [7:0] gap);
      integer i;
      cs_n = 1'b0;
      #150;
      for (i = 15; i >= 0; i--) begin
         sdi = w[i];
         #100;
         sclk = 1'b1;
         #100;
         rd[i] = sdo;
         sclk = 1'b0;
      end
      #300;
      cs_n = 1'b1;
      sdi  = ~sdi;
      done = 1'b1;
      #25;
      done = 1'b0;
      #(400 + gap);
   endtask
endmodule // adcsfs_host
`default_nettype wire

// [bench/tb_adcsfs_top.sv]
// self-checking bench for the frame sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adcsfs_top;
   logic        CLK;
   logic        RESETN;
   logic [11:0] CONV_RESULT;
   logic [3:0]  GPIO_IN;
   wire  logic  CS_N, SCLK, SDI, SDO_OUT, SDO_OE, SAMPLE_STROBE, CONVERTING, ACQUIRE;
   wire  logic  RANGE_SEL, POWERED_DOWN, DONE, SDO_W;
   wire  logic [3:0]  GPIO_OUT, GPIO_OE, MUX_CH, SAMPLE_CH;
   wire  logic [15:0] RD;
   logic [31:0] seed = 32'h0000_fd3c;
   logic [31:0] v;
   logic [11:0] or_m = 12'h000, and_m = 12'hfff;
   logic [3:0]  mux_m = 4'h0, man_m = 4'h0, last_m = 4'h3, mask_m = 4'hf;
   logic [1:0]  mode_m = 2'd0;
   logic        rst_m = 1'b0, arm_m = 1'b0, rb_m = 1'b0;
   logic [15:0] expq[$];
   integer      err_total = 0;
   integer      checks = 0;
   integer      cyc = 0;
   assign SDO_W = SDO_OE ? SDO_OUT : ~SDO_OUT;
   adcsfs_top #(.NUM_CH(4), .RES_BITS(12)) adcsfs_top_inst (
      .CLK, .RESETN, .CS_N, .SCLK, .SDI, .CONV_RESULT, .GPIO_IN, .SDO_OUT, .SDO_OE,
      .GPIO_OUT, .GPIO_OE, .MUX_CH, .SAMPLE_CH, .SAMPLE_STROBE, .CONVERTING, .ACQUIRE,
      .RANGE_SEL, .POWERED_DOWN
   );
   adcsfs_host adcsfs_host_inst (
      .cs_n(CS_N), .sclk(SCLK), .sdi(SDI), .rd(RD), .done(DONE), .sdo(SDO_W)
   );
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // channel the mux takes at the second fall
   function automatic logic [3:0] nxt();
      logic [3:0] c;
      c = rst_m ? 4'h3 : mux_m;
      if (mode_m == 2'd0)
         return man_m;
      if (mode_m == 2'd2)
         return (rst_m || mux_m >= last_m) ? 4'h0 : mux_m + 4'h1;
      repeat (4) begin
         c = (c + 4'h1) & 4'h3;
         if (mask_m[c[1:0]])
            return c;
      end
      return c;
   endfunction
   task automatic decode(input logic [15:0] w);
      if (arm_m) begin
         mask_m = w[3:0];
         arm_m  = 1'b0;
      end else if (w[15:12] == 4'h8)
         arm_m = 1'b1;
      else if (w[15:12] == 4'h9)
         last_m = w[9:6];
      else if (w[15:14] == 2'b00 && w[13:12] != 2'b00) begin
         mode_m = w[13:12] - 2'd1;
         if (w[11]) begin
            rb_m = w[4];
            if (w[13:12] == 2'b01)
               man_m = w[10:7];
            else
               rst_m = w[10];
         end
      end
   endtask
   task automatic fr(input logic [15:0] w);
      logic [31:0] r;
      r = rnd();
      @(posedge CLK);
      #2;
      CONV_RESULT = r[11:0] & and_m | or_m;
      GPIO_IN = {1'b1, r[14:12]};
      repeat (6) @(posedge CLK);
      #2;
      expq.push_back({rb_m ? GPIO_IN : mux_m, CONV_RESULT});
      mux_m = nxt();
      rst_m = 1'b0;
      decode(w);
      adcsfs_host_inst.xfer(w, r[23:16]);
   endtask
   always @(posedge DONE) chk(RD, expq.pop_front());
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total = err_total + 1;
         conclude();
      end
   end
   initial begin
      RESETN = 1'b0;
      CONV_RESULT = 12'h000;
      GPIO_IN = 4'hf;
      repeat (12) @(posedge CLK);
      #2;
      RESETN = 1'b1;
      repeat (6) @(posedge CLK);
      chk(16'(MUX_CH), 16'h0000);
      repeat (8) begin
         v = rnd();
         fr({4'h1, v[11], 2'b00, v[1:0], 7'h00});
      end
      $display("test manual done");
      fr(16'h2C00);
      repeat (5) fr(16'h0000);
      fr(16'h3C00);
      repeat (5) fr(16'h0000);
      fr(16'h9040);
      fr(16'h8000);
      fr(16'h000A);
      repeat (3) fr(16'h0000);
      fr(16'h1800);
      fr(16'h2C00);
      repeat (4) fr(16'h0000);
      $display("test scan done");
      fr(16'h1800);
      fr(16'h400F);
      v = rnd();
      fr({4'h1, 1'b1, 4'h0, v[6], 2'b00, v[3:0]});
      chk(16'(GPIO_OUT), 16'h0000);
      fr(16'h0000);
      chk({11'h000, RANGE_SEL, GPIO_OUT}, {11'h000, v[6], v[3:0]});
      chk(16'(GPIO_OE), 16'h000F);
      fr(16'h4000);
      fr(16'h1810);
      repeat (2) fr(16'h0000);
      fr(16'h1800);
      $display("test gpio done");
      fr(16'h1820);
      chk(16'(POWERED_DOWN), 16'h0000);
      fr(16'h0000);
      chk(16'(POWERED_DOWN), 16'h0001);
      fr(16'h1800);
      fr(16'h0000);
      chk(16'(POWERED_DOWN), 16'h0000);
      fr(16'h4040);
      @(posedge CLK);
      #2;
      GPIO_IN = 4'h7;
      repeat (10) @(posedge CLK);
      chk(16'(POWERED_DOWN), 16'h0001);
      fr(16'h0000);
      chk(16'(POWERED_DOWN), 16'h0000);
      $display("test powerdown done");
      and_m = 12'h7ff;
      fr(16'h4011);
      fr(16'hD080);
      or_m = 12'hf00;
      fr(16'h0000);
      chk(16'(GPIO_OUT[0]), 16'h0001);
      or_m = 12'h000;
      fr(16'h0000);
      chk(16'(GPIO_OUT[0]), 16'h0000);
      fr(16'h4022);
      fr(16'hC080);
      fr(16'h0000);
      chk(16'(GPIO_OUT[1]), 16'h0001);
      or_m = 12'hf00;
      fr(16'h0000);
      chk(16'(GPIO_OUT[1]), 16'h0000);
      $display("test alarm done");
      conclude();
   end
endmodule // tb_adcsfs_top
`default_nettype wire
